// ---- common/rcit_pkg.sv ----
// rcit_pkg: register map, field positions and reset values for the radio
// core interrupt and timebase block.
// assumes a 32-bit APB register bus with byte addresses as listed here.
package rcit_pkg;

	// register byte addresses
	localparam logic [31:0] RCIT_CTRL_ADDR       = 32'h4000_0000;
	localparam logic [31:0] RCIT_MASK_ADDR       = 32'h4000_000c;
	localparam logic [31:0] RCIT_MASKED_ADDR     = 32'h4000_0010;
	localparam logic [31:0] RCIT_RAW_ADDR        = 32'h4000_0014;
	localparam logic [31:0] RCIT_ACK_ADDR        = 32'h4000_0018;
	localparam logic [31:0] RCIT_SLOT_SNAP_ADDR  = 32'h4000_001c;
	localparam logic [31:0] RCIT_US_SNAP_ADDR    = 32'h4000_0020;
	localparam logic [31:0] RCIT_ADDR_LOW_ADDR   = 32'h4000_0024;
	localparam logic [31:0] RCIT_ADDR_HIGH_ADDR  = 32'h4000_0028;
	localparam logic [31:0] RCIT_SAMPLE_ADDR     = 32'h4000_00fc;

	// interrupt source bit positions
	localparam int RCIT_SRC_COUNT      = 10;
	localparam int RCIT_SRC_SLOT       = 0;
	localparam int RCIT_SRC_RECEIVE    = 1;
	localparam int RCIT_SRC_SLEEP_END  = 2;
	localparam int RCIT_SRC_EVENT_END  = 3;
	localparam int RCIT_SRC_CIPHER     = 4;
	localparam int RCIT_SRC_FAULT      = 5;
	localparam int RCIT_SRC_GROSS      = 6;
	localparam int RCIT_SRC_FINE       = 7;
	localparam int RCIT_SRC_EVT_ABORT  = 8;
	localparam int RCIT_SRC_SOFT       = 9;

	// field positions in the mask, control and upper address registers
	localparam int RCIT_SLOT_IN_EVT_BIT = 15;
	localparam int RCIT_SOFT_REQ_BIT    = 28;
	localparam int RCIT_REG_RESET_BIT   = 29;
	localparam int RCIT_PRIVATE_BIT     = 16;
	localparam int RCIT_ADDR_HIGH_W     = 16;

	// values after reset
	localparam logic [9:0] RCIT_MASK_RESET        = 10'h11f;
	localparam logic       RCIT_SLOT_IN_EVT_RESET = 1'b1;

	// documented counter widths and base period
	localparam int RCIT_SLOT_W_DEF   = 27;
	localparam int RCIT_US_W_DEF     = 10;
	localparam int RCIT_SLOT_US      = 625;

endpackage

// ---- hw/rcit_irq_timebase.sv ----
// rcit_irq_timebase: interrupt mask, pending and acknowledge logic for the
// ten radio core sources, counter snapshots and device address registers.
// assumes sources arrive as one-cycle pulses synchronous to ref_clk, and the
// core's slot and microsecond counters are driven in the same clock domain.
//
// Summary of operation
// - every source has its own enable bit
// - sources occupy bits zero to nine
// - bit 15 allows slot irq during events
// - mask resets with documented ones and zeros
// - masked status is pending and enabled
// - raw status ignores mask except bit 15, resets zero
// - writing one acknowledges, clearing both flags
// - acknowledge bits never hold, read zero
// - irq lines stay high until acknowledged or masked
// - control request bit raises soft source
// - 27-bit slot counter copy, zero at reset
// - copies refresh only on sampling write
// - 10-bit microsecond counter copy
// - 48-bit address in two registers
// - bit 16 flags private address
// - event end and abort sources separate
`timescale 1ns/1ns
module rcit_irq_timebase
	import rcit_pkg::*;
#(
	parameter int SLOT_W = RCIT_SLOT_W_DEF,
	parameter int US_W   = RCIT_US_W_DEF
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	input  wire logic                      ce,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [RCIT_SRC_COUNT-2:0] srcEvent,
	input  wire logic                      inEvent,
	input  wire logic [SLOT_W-1:0]         slotCount,
	input  wire logic [US_W-1:0]           microsecondCount,
	output logic [RCIT_SRC_COUNT-1:0]      irqLines,
	output logic                           irq,
	output logic [47:0]                    deviceAddress,
	output logic                           addressIsPrivate
);

	// the slot copy must fit one 32-bit register word
	if (SLOT_W < 1 || SLOT_W > 32) begin : g_slot_width_check
		$error("rcit_irq_timebase: SLOT_W must be 1 to 32");
	end

	// the microsecond copy must fit one register word as well
	if (US_W < 1 || US_W > 32) begin : g_us_width_check
		$error("rcit_irq_timebase: US_W must be 1 to 32");
	end

	// the privacy flag sits above the upper address part
	if (RCIT_PRIVATE_BIT < RCIT_ADDR_HIGH_W) begin : g_priv_bit_check
		$error("rcit_irq_timebase: privacy bit overlaps the upper address");
	end

	// the in-event enable must not overlap a source mask bit
	if (RCIT_SLOT_IN_EVT_BIT < RCIT_SRC_COUNT) begin : g_mask_bit_check
		$error("rcit_irq_timebase: in-event enable overlaps a source bit");
	end

	// all state of the block, grouped by what software sees of it
	typedef struct packed {
		// enable mask word
		logic [RCIT_SRC_COUNT-1:0]   mask;
		logic                        slotInEvt;

		// pending flags and the one-cycle soft request
		logic [RCIT_SRC_COUNT-1:0]   raw;
		logic                        softReq;

		// counter copies, refreshed only by a sampling write
		logic [SLOT_W-1:0]           slotSnap;
		logic [US_W-1:0]             usSnap;

		// device address and its privacy flag
		logic [31:0]                 addrLow;
		logic [RCIT_ADDR_HIGH_W-1:0] addrHigh;
		logic                        priv;

		// bus answer, standing for one cycle
		logic                        ready;
		logic [31:0]                 rdata;
		logic                        slverr;

		// interrupt outputs, registered so they never glitch
		logic [RCIT_SRC_COUNT-1:0]   lines;
		logic                        irqAny;
	} rcit_state_t;

	// values after reset: documented mask ones and the in-event enable set, everything else clear
	localparam rcit_state_t RCIT_STATE_RESET = '{
		mask:      RCIT_MASK_RESET,
		slotInEvt: RCIT_SLOT_IN_EVT_RESET,
		raw:       '0,
		softReq:   1'b0,
		slotSnap:  '0,
		usSnap:    '0,
		addrLow:   32'h0,
		addrHigh:  '0,
		priv:      1'b0,
		ready:     1'b0,
		rdata:     32'h0,
		slverr:    1'b0,
		lines:     '0,
		irqAny:    1'b0
	};

	rcit_state_t stateReg;
	rcit_state_t stateNext;

	// bus handshake, decode and pending flag vectors
	logic                      setupPhase;
	logic                      accessDone;
	logic                      wrDone;
	logic                      addrHit;
	logic [31:0]               readWord;
	logic [RCIT_SRC_COUNT-1:0] setVec;
	logic [RCIT_SRC_COUNT-1:0] ackVec;
	logic                      regReset;

	// per-register address matches and write strobes
	logic                      hitCtrl;
	logic                      hitMask;
	logic                      hitMasked;
	logic                      hitRaw;
	logic                      hitAck;
	logic                      hitSlotSnap;
	logic                      hitUsSnap;
	logic                      hitAddrLow;
	logic                      hitAddrHigh;
	logic                      hitSample;
	logic                      wrCtrl;
	logic                      wrAck;

	// source gating and readable register words
	logic                      slotAllowed;
	logic [RCIT_SRC_COUNT-1:0] maskedView;
	logic [31:0]               maskWord;
	logic [31:0]               maskedWord;
	logic [31:0]               rawWord;
	logic [31:0]               slotWord;
	logic [31:0]               usWord;
	logic [31:0]               highWord;

	// first access cycle answers next edge; completing edge commits writes
	assign setupPhase = psel && penable && !stateReg.ready;
	assign accessDone = psel && penable && stateReg.ready;
	assign wrDone     = accessDone && pwrite && addrHit;

	// one exact compare per register, so no alias answers
	assign hitCtrl     = (paddr == RCIT_CTRL_ADDR);
	assign hitMask     = (paddr == RCIT_MASK_ADDR);
	assign hitMasked   = (paddr == RCIT_MASKED_ADDR);
	assign hitRaw      = (paddr == RCIT_RAW_ADDR);
	assign hitAck      = (paddr == RCIT_ACK_ADDR);
	assign hitSlotSnap = (paddr == RCIT_SLOT_SNAP_ADDR);
	assign hitUsSnap   = (paddr == RCIT_US_SNAP_ADDR);
	assign hitAddrLow  = (paddr == RCIT_ADDR_LOW_ADDR);
	assign hitAddrHigh = (paddr == RCIT_ADDR_HIGH_ADDR);
	assign hitSample   = (paddr == RCIT_SAMPLE_ADDR);

	// unmapped addresses answer with an error and change nothing
	assign addrHit = hitCtrl || hitMask || hitMasked || hitRaw || hitAck || hitSlotSnap || hitUsSnap
		|| hitAddrLow || hitAddrHigh || hitSample;

	// strobes alive only on the completing edge of a write
	assign wrCtrl = wrDone && hitCtrl;
	assign wrAck  = wrDone && hitAck;

	// masked view: pending and enabled
	assign maskedView = stateReg.raw & stateReg.mask;

	// readable registers as full words; bits outside the fields read zero
	always_comb begin
		maskWord                       = '0;
		maskWord[RCIT_SRC_COUNT-1:0]   = stateReg.mask;
		maskWord[RCIT_SLOT_IN_EVT_BIT] = stateReg.slotInEvt;
		maskedWord                     = '0;
		maskedWord[RCIT_SRC_COUNT-1:0] = maskedView;
		rawWord                        = '0;
		rawWord[RCIT_SRC_COUNT-1:0]    = stateReg.raw;
		slotWord                       = '0;
		slotWord[SLOT_W-1:0]           = stateReg.slotSnap;
		usWord                         = '0;
		usWord[US_W-1:0]               = stateReg.usSnap;
		highWord                       = '0;
		highWord[RCIT_ADDR_HIGH_W-1:0] = stateReg.addrHigh;
		highWord[RCIT_PRIVATE_BIT]     = stateReg.priv;
	end

	// read multiplexer; write-only and self-clearing words read zero
	always_comb begin
		readWord = '0;
		unique case (paddr)
			RCIT_MASK_ADDR: begin
				readWord = maskWord;
			end
			RCIT_MASKED_ADDR: begin
				readWord = maskedWord;
			end
			RCIT_RAW_ADDR: begin
				readWord = rawWord;
			end
			RCIT_SLOT_SNAP_ADDR: begin
				readWord = slotWord;
			end
			RCIT_US_SNAP_ADDR: begin
				readWord = usWord;
			end
			RCIT_ADDR_LOW_ADDR: begin
				readWord = stateReg.addrLow;
			end
			RCIT_ADDR_HIGH_ADDR: begin
				readWord = highWord;
			end
			RCIT_CTRL_ADDR: begin
				readWord = '0;
			end
			RCIT_ACK_ADDR: begin
				readWord = '0;
			end
			RCIT_SAMPLE_ADDR: begin
				readWord = '0;
			end
			default: begin
				readWord = '0;
			end
		endcase
	end

	// acknowledge pulses exist only for the completing write edge
	assign ackVec = wrAck ? pwdata[RCIT_SRC_COUNT-1:0] : '0;

	// block reset request; unlike the soft request it is never stored
	assign regReset = wrCtrl && pwdata[RCIT_REG_RESET_BIT];

	// slot source is held off during events unless bit 15 allows it
	assign slotAllowed = !inEvent || stateReg.slotInEvt;

	// hardware sources in their bit order; the soft source comes from the request flop
	always_comb begin
		setVec                     = '0;
		setVec[RCIT_SRC_SLOT]      = srcEvent[RCIT_SRC_SLOT] && slotAllowed;
		setVec[RCIT_SRC_RECEIVE]   = srcEvent[RCIT_SRC_RECEIVE];
		setVec[RCIT_SRC_SLEEP_END] = srcEvent[RCIT_SRC_SLEEP_END];
		setVec[RCIT_SRC_EVENT_END] = srcEvent[RCIT_SRC_EVENT_END];
		setVec[RCIT_SRC_CIPHER]    = srcEvent[RCIT_SRC_CIPHER];
		setVec[RCIT_SRC_FAULT]     = srcEvent[RCIT_SRC_FAULT];
		setVec[RCIT_SRC_GROSS]     = srcEvent[RCIT_SRC_GROSS];
		setVec[RCIT_SRC_FINE]      = srcEvent[RCIT_SRC_FINE];
		setVec[RCIT_SRC_EVT_ABORT] = srcEvent[RCIT_SRC_EVT_ABORT];
		setVec[RCIT_SRC_SOFT]      = stateReg.softReq;
	end

	// next-state logic for the whole block
	always_comb begin
		stateNext = stateReg;

		// bus answer: one wait state, data and error stand with pready
		stateNext.ready  = setupPhase;
		stateNext.rdata  = setupPhase ? readWord : '0;
		stateNext.slverr = setupPhase && !addrHit;

		// soft request lasts one cycle, then raises the soft source
		stateNext.softReq = wrCtrl && pwdata[RCIT_SOFT_REQ_BIT];

		// pending flags are sticky; a new event wins over its acknowledge
		stateNext.raw = (stateReg.raw & ~ackVec) | setVec;

		// register block soft reset leaves pending flags untouched
		if (regReset) begin
			stateNext.mask      = RCIT_MASK_RESET;
			stateNext.slotInEvt = RCIT_SLOT_IN_EVT_RESET;
			stateNext.slotSnap  = '0;
			stateNext.usSnap    = '0;
			stateNext.addrLow   = '0;
			stateNext.addrHigh  = '0;
			stateNext.priv      = 1'b0;
		end

		if (wrDone && !regReset) begin
			unique case (paddr)
				RCIT_MASK_ADDR: begin
					stateNext.mask      = pwdata[RCIT_SRC_COUNT-1:0];
					stateNext.slotInEvt = pwdata[RCIT_SLOT_IN_EVT_BIT];
				end
				RCIT_SAMPLE_ADDR: begin
					stateNext.slotSnap = slotCount;
					stateNext.usSnap   = microsecondCount;
				end
				RCIT_ADDR_LOW_ADDR: begin
					stateNext.addrLow = pwdata;
				end
				RCIT_ADDR_HIGH_ADDR: begin
					stateNext.addrHigh = pwdata[RCIT_ADDR_HIGH_W-1:0];
					stateNext.priv     = pwdata[RCIT_PRIVATE_BIT];
				end
				default: begin
					// read-only and strobe-only words store nothing here
					stateNext.addrLow = stateReg.addrLow;
				end
			endcase
		end

		// outputs follow the registered state so they never glitch
		stateNext.lines  = stateNext.raw & stateNext.mask;
		stateNext.irqAny = |stateNext.lines;
	end

	// single state register, frozen while the clock enable is low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg <= RCIT_STATE_RESET;
		end else if (ce) begin
			stateReg <= stateNext;
		end
	end

	// bus answer straight from the state register
	assign prdata           = stateReg.rdata;
	assign pready           = stateReg.ready;
	assign pslverr          = stateReg.slverr;

	// interrupt lines, level until acknowledged or masked
	assign irqLines         = stateReg.lines;
	assign irq              = stateReg.irqAny;

	// address registers as seen by the link layer
	assign deviceAddress    = {stateReg.addrHigh, stateReg.addrLow};
	assign addressIsPrivate = stateReg.priv;

endmodule

// ---- tb/rcit_irq_timebase_sva.sv ----
// rcit_irq_timebase_sva: port checks for the irq and timebase block.
// assumes one ref_clk domain and rst_n asynchronous, active low.
`timescale 1ns/1ns
module rcit_irq_timebase_sva
	import rcit_pkg::*;
(
	input wire logic                      ref_clk,
	input wire logic                      rst_n,
	input wire logic                      ce,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [31:0]               paddr,
	input wire logic [31:0]               pwdata,
	input wire logic [31:0]               prdata,
	input wire logic                      pready,
	input wire logic [RCIT_SRC_COUNT-2:0] srcEvent,
	input wire logic [RCIT_SRC_COUNT-1:0] irqLines,
	input wire logic                      irq,
	input wire logic [47:0]               deviceAddress,
	input wire logic                      addressIsPrivate
);
	logic wr;
	// a committed write is the only cause besides a source pulse that may move a flag
	assign wr = psel && penable && pready && pwrite && ce;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_irq_any_line: assert property (irq == (irqLines != 10'h0)) else $error("irq not OR of lines");
	chk_line_holds: assert property (|($past(irqLines) & ~irqLines) |-> $past(wr))
		else $error("irq line fell without a write");
	chk_line_cause: assert property (|(irqLines[8:0] & ~$past(irqLines[8:0]) & ~$past(srcEvent)) |-> $past(wr))
		else $error("irq line rose without a cause");
	chk_ack_clears: assert property (wr && paddr == RCIT_ACK_ADDR && pwdata[3] && !srcEvent[3] |=> !irqLines[3])
		else $error("event end line not cleared");
	chk_ack_reads_zero: assert property (psel && !pwrite && pready && paddr == RCIT_ACK_ADDR |-> prdata == 32'h0)
		else $error("acknowledge reads nonzero");
	chk_addr_low: assert property (wr && paddr == RCIT_ADDR_LOW_ADDR |=> deviceAddress[31:0] == $past(pwdata))
		else $error("low address not written");
	chk_addr_priv: assert property (wr && paddr == RCIT_ADDR_HIGH_ADDR |=> addressIsPrivate == $past(pwdata[16]))
		else $error("privacy flag not written");
	chk_addr_stable: assert property (!$stable(deviceAddress) |-> $past(wr)) else $error("address moved");
	cover property (wr && paddr == RCIT_ACK_ADDR);
	cover property ($rose(irq));
	cover property ($rose(addressIsPrivate));
endmodule
bind rcit_irq_timebase rcit_irq_timebase_sva chk (.ref_clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .srcEvent, .irqLines, .irq, .deviceAddress, .addressIsPrivate);

// ---- tb/tb_radio_core_irq_and_timebase.sv ----
// tb_radio_core_irq_and_timebase: directed APB and source-pin scenarios.
// assumes ce held high; the bench plays the live counters and sources.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin nErrors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_radio_core_irq_and_timebase import rcit_pkg::*;;
	logic        ref_clk = '0, rst_n = '0, ce = 1'h1, psel = '0, penable = '0, pwrite = '0, inEvent = '0, err;
	logic        pready, pslverr, irq, addressIsPrivate;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic [8:0]  srcEvent = '0;
	logic [9:0]  irqLines, microsecondCount = '0;
	logic [26:0] slotCount = '0;
	logic [47:0] deviceAddress;
	int          nErrors = 0, checksDone = 0;
	rcit_irq_timebase dut (.ref_clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .srcEvent, .inEvent, .slotCount, .microsecondCount, .irqLines, .irq, .deviceAddress, .addressIsPrivate);
	initial forever #5 ref_clk = ~ref_clk;
	task automatic printVerdict();
		$display("errors %0d checks %0d", nErrors, checksDone);
		if (nErrors == 0 && checksDone > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// one transfer; held until pready is seen, then one idle edge so psel never toggles twice
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
		if (n >= 20) begin
			nErrors++;
			printVerdict();
		end
	endtask
	task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask
	task automatic pulse(input logic [8:0] s);
		srcEvent <= s;
		@(posedge ref_clk);
		srcEvent <= '0;
		@(posedge ref_clk);
	endtask
	task automatic tReset();
		rdchk("mask", RCIT_MASK_ADDR, 32'h0000_811f);
		rdchk("raw", RCIT_RAW_ADDR, 32'h0);
		rdchk("slot", RCIT_SLOT_SNAP_ADDR, 32'h0);
		rdchk("addrhi", RCIT_ADDR_HIGH_ADDR, 32'h0);
	endtask
	// each hardware source alone; lines must still stand after two reads
	task automatic tSources();
		for (int i = 0; i < 9; i++) begin
			pulse(9'h1 << i);
			rdchk("raw", RCIT_RAW_ADDR, 32'h1 << i);
			rdchk("masked", RCIT_MASKED_ADDR, (32'h1 << i) & 32'h11f);
			`CHK("lines", (10'h1 << i) & 10'h11f, irqLines)
			`CHK("irq", |((10'h1 << i) & 10'h11f), irq)
			apb(1'h1, RCIT_ACK_ADDR, 32'h1 << i);
			rdchk("acked", RCIT_RAW_ADDR, 32'h0);
		end
		rdchk("ack", RCIT_ACK_ADDR, 32'h0);
	endtask
	task automatic tInEvent();
		inEvent <= 1'h1;
		pulse(9'h1);
		rdchk("slotev", RCIT_RAW_ADDR, 32'h1);
		apb(1'h1, RCIT_ACK_ADDR, 32'h1);
		apb(1'h1, RCIT_MASK_ADDR, 32'h1f);
		pulse(9'h1);
		rdchk("gated", RCIT_RAW_ADDR, 32'h0);
		inEvent <= 1'h0;
	endtask
	task automatic tSoft();
		apb(1'h1, RCIT_MASK_ADDR, 32'h200);
		apb(1'h1, RCIT_CTRL_ADDR, 32'h1000_0000);
		rdchk("soft", RCIT_MASKED_ADDR, 32'h200);
		`CHK("softline", 10'h200, irqLines)
		rdchk("ctrl", RCIT_CTRL_ADDR, 32'h0);
		apb(1'h1, RCIT_ACK_ADDR, 32'h200);
		`CHK("softirq", 1'h0, irq)
	endtask
	task automatic tSnap();
		slotCount <= 27'h5a5_a5a5;
		microsecondCount <= 10'h270;
		rdchk("nosample", RCIT_SLOT_SNAP_ADDR, 32'h0);
		apb(1'h1, RCIT_SAMPLE_ADDR, 32'h0);
		slotCount <= 27'h0;
		rdchk("slotsnap", RCIT_SLOT_SNAP_ADDR, 32'h05a5_a5a5);
		rdchk("ussnap", RCIT_US_SNAP_ADDR, 32'h270);
	endtask
	task automatic tAddr();
		apb(1'h1, RCIT_ADDR_LOW_ADDR, 32'h1234_5678);
		apb(1'h1, RCIT_ADDR_HIGH_ADDR, 32'hffff_ffff);
		rdchk("addrhi", RCIT_ADDR_HIGH_ADDR, 32'h0001_ffff);
		`CHK("addr", 48'hffff_1234_5678, deviceAddress)
		`CHK("priv", 1'h1, addressIsPrivate)
		apb(1'h0, 32'h4000_0004, 32'h0);
		`CHK("slverr", 1'h1, err)
	endtask
	// block soft reset restores registers but pending flags wait for software
	task automatic tRegReset();
		apb(1'h1, RCIT_MASK_ADDR, 32'h3ff);
		pulse(9'h2);
		apb(1'h1, RCIT_CTRL_ADDR, 32'h2000_0000);
		rdchk("rstmask", RCIT_MASK_ADDR, 32'h0000_811f);
		rdchk("rstaddr", RCIT_ADDR_LOW_ADDR, 32'h0);
		rdchk("rstraw", RCIT_RAW_ADDR, 32'h2);
		apb(1'h1, RCIT_ACK_ADDR, 32'h2);
		rdchk("rstack", RCIT_RAW_ADDR, 32'h0);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		tReset();
		tSources();
		tInEvent();
		tSoft();
		tSnap();
		tAddr();
		tRegReset();
		printVerdict();
	end
endmodule
